// file: shared/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
  // bus geometry of the flash word interface
  localparam int FA_W    = 26;          // word address width
  localparam int FD_W    = 16;          // data width
  localparam int SEC_LSB = 16;          // sector select starts at word address bit 16
  localparam int SEC_W   = FA_W - SEC_LSB;
  localparam int PAT_W   = 11;          // command pattern on word address bits 10..0
  localparam int TGL_BIT = 6;           // toggle_flag position in polled data
  localparam int PWD_WORDS = 4;         // 64-bit password as four words
  localparam int PMODE_BIT = 1;         // persistent_mode_bit in lock word
  localparam int WMODE_BIT = 2;         // password_mode_bit in lock word
  // timing, figures in ns, cycle counts derived from the 40 ns clock
  localparam int CLK_NS  = 40;
  localparam int T_WP_NS = 35;          // write strobe low width
  localparam int T_ACC_NS = 90;         // random read access
  localparam int T_RP_NS = 200;         // hardware reset pulse low
  localparam int T_RH_NS = 50;          // recovery after hardware reset
  localparam int SYNC_CYC = 2;          // data input synchroniser depth
  localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RH_CYC  = 8'((T_RH_NS + CLK_NS - 1) / CLK_NS);
  // command patterns and codes sent over the bus
  localparam logic [PAT_W-1:0] UNL1_PAT = 11'h123;
  localparam logic [PAT_W-1:0] UNL2_PAT = 11'h0dc;
  localparam logic [FD_W-1:0] UNL1_DAT  = 16'h00a5;
  localparam logic [FD_W-1:0] UNL2_DAT  = 16'h005a;
  localparam logic [FD_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [FD_W-1:0] CMD_NV_ENTER   = 16'h00c1;
  localparam logic [FD_W-1:0] CMD_GUARD_ENTER = 16'h00c2;
  localparam logic [FD_W-1:0] CMD_LOCK_ENTER = 16'h00c3;
  localparam logic [FD_W-1:0] CMD_WORD_PGM  = 16'h00b1;
  localparam logic [FD_W-1:0] CMD_ERASE     = 16'h00b2;
  localparam logic [FD_W-1:0] CMD_CONFIRM   = 16'h00b3;
  localparam logic [FD_W-1:0] CMD_UNLOCK    = 16'h00b4;
  localparam logic [FD_W-1:0] CMD_EXIT      = 16'h00b5;
  localparam logic [FD_W-1:0] DAT_ZERO      = 16'h0000;
  localparam logic [FA_W-1:0] ADDR_ZERO     = 26'h0000000;
  localparam logic [3:0] STEP_BODY = 4'h3;  // first step after the entry prefix

  // user operations
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_WRITE = 4'h1, OP_RESET_CMD = 4'h2, OP_HW_RESET = 4'h3,
    OP_NV_PROG = 4'h4, OP_NV_ERASE = 4'h5, OP_NV_STATUS = 4'h6,
    OP_GUARD_CLEAR = 4'h7, OP_GUARD_UNLOCK = 4'h8, OP_MODE_PROG = 4'h9
  } fsp_op_e;
  typedef enum logic [1:0] {
    RS_OK = 2'h0, RS_REFUSED = 2'h1, RS_TIMEOUT = 2'h2
  } fsp_stat_e;
  typedef enum logic [1:0] {
    SK_END = 2'h0, SK_W = 2'h1, SK_R = 2'h2, SK_POLL = 2'h3
  } fsp_kind_e;
  typedef struct packed {
    fsp_op_e         op;
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] data;
  } fsp_req_s;
  typedef struct packed {
    fsp_kind_e       kind;
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] data;
  } fsp_step_s;
  typedef struct packed {
    logic            reset_n;
    logic            ce_n;
    logic            oe_n;
    logic            we_n;
    logic            wp_n;
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] dq_out;
    logic            dq_oe;
  } fsp_pins_s;
  localparam fsp_pins_s PINS_IDLE = '{reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      wp_n: 1'b1, addr: ADDR_ZERO, dq_out: DAT_ZERO,
                                      dq_oe: 1'b0};
endpackage
`default_nettype wire

// file: design/fsp_host.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_host
  import fsp_pkg::*;
#(
  parameter logic [23:0] POLL_MAX = 24'hffffff  // toggle reads before giving up
)(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // user request port
  input  wire logic            req_valid,
  input  wire fsp_req_s        req,
  input  wire logic [63:0]     pwd,
  input  wire logic            nv_ready,
  input  wire logic            wp_protect,
  // user answer port
  output logic                 busy,
  output logic                 resp_done,
  output fsp_stat_e            resp_stat,
  output logic [FD_W-1:0]      resp_rdata,
  // flash pins
  output fsp_pins_s            pins,
  input  wire logic [FD_W-1:0] dq_in
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_FETCH = 4'h1, S_WSETUP = 4'h2, S_WSTRB = 4'h3, S_WHOLD = 4'h4,
    S_RWAIT = 4'h5, S_HWRST = 4'h6, S_HWREC = 4'h7
  } fsp_state_e;

  fsp_state_e      state, next_state;           // bus engine state
  fsp_req_s        req_q, next_req_q;           // captured request
  logic [63:0]     pwd_q, next_pwd_q;           // captured password
  logic [3:0]      step, next_step;             // index into the sequence
  logic [7:0]      cnt, next_cnt;               // phase timer
  logic [23:0]     poll_cnt, next_poll_cnt;     // toggle reads spent
  logic            poll_first, next_poll_first; // no reference toggle yet
  logic            prev_tgl, next_prev_tgl;     // last toggle_flag value seen
  fsp_pins_s       next_pins;
  logic            next_busy, next_resp_done;
  fsp_stat_e       next_resp_stat;
  logic [FD_W-1:0] next_resp_rdata;
  logic [FD_W-1:0] dq_meta, dq_sync;            // two-flop data synchroniser
  fsp_step_s       cur;                         // step now due

  // word address with sector select above and command pattern below
  function automatic logic [FA_W-1:0] cmd_addr(input logic [FA_W-1:0] a,
                                               input logic [PAT_W-1:0] pat);
    cmd_addr = {a[FA_W-1:SEC_LSB], {(SEC_LSB-PAT_W){1'b0}}, pat};
  endfunction

  // sector base word address
  function automatic logic [FA_W-1:0] sec_base(input logic [FA_W-1:0] a);
    sec_base = {a[FA_W-1:SEC_LSB], {SEC_LSB{1'b0}}};
  endfunction

  function automatic fsp_step_s mk(input fsp_kind_e k, input logic [FA_W-1:0] a,
                                   input logic [FD_W-1:0] d);
    mk = '{kind: k, addr: a, data: d};
  endfunction

  // sequence table: overlay ops share an unlock and entry prefix
  function automatic fsp_step_s seq_step(input fsp_req_s r, input logic [3:0] s,
                                         input logic [63:0] pw);
    logic [FD_W-1:0] enter;
    logic [3:0]      b;
    enter = CMD_NV_ENTER;
    b = s - STEP_BODY;
    seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
    if (r.op == OP_GUARD_CLEAR || r.op == OP_GUARD_UNLOCK)
    begin
      enter = CMD_GUARD_ENTER;
    end
    else if (r.op == OP_MODE_PROG)
    begin
      enter = CMD_LOCK_ENTER;
    end
    case (r.op)
      OP_READ:      if (s == 4'h0) seq_step = mk(SK_R, r.addr, DAT_ZERO);
      OP_WRITE:     if (s == 4'h0) seq_step = mk(SK_W, r.addr, r.data);
      OP_RESET_CMD: if (s == 4'h0) seq_step = mk(SK_W, ADDR_ZERO, CMD_RESET);
      OP_HW_RESET:  seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
      default:
      begin
        if (s == 4'h0)
          seq_step = mk(SK_W, cmd_addr(r.addr, UNL1_PAT), UNL1_DAT);
        else if (s == 4'h1)
          seq_step = mk(SK_W, cmd_addr(r.addr, UNL2_PAT), UNL2_DAT);
        else if (s == 4'h2)
          seq_step = mk(SK_W, cmd_addr(r.addr, UNL1_PAT), enter);
        else
        begin
          case (r.op)
            OP_NV_PROG:  // one sector bit at a time, then wait on the toggle
              case (b)
                4'h0: seq_step = mk(SK_W, ADDR_ZERO, CMD_WORD_PGM);
                4'h1: seq_step = mk(SK_W, sec_base(r.addr), DAT_ZERO);
                4'h2: seq_step = mk(SK_POLL, ADDR_ZERO, DAT_ZERO);
                4'h3: seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
                default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
              endcase
            OP_NV_ERASE: // whole set erased together
              case (b)
                4'h0: seq_step = mk(SK_W, ADDR_ZERO, CMD_ERASE);
                4'h1: seq_step = mk(SK_W, ADDR_ZERO, CMD_CONFIRM);
                4'h2: seq_step = mk(SK_POLL, ADDR_ZERO, DAT_ZERO);
                4'h3: seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
                default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
              endcase
            OP_NV_STATUS: // sector bit read back inside the overlay
              case (b)
                4'h0: seq_step = mk(SK_R, sec_base(r.addr), DAT_ZERO);
                4'h1: seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
                default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
              endcase
            OP_GUARD_CLEAR:
              case (b)
                4'h0: seq_step = mk(SK_W, ADDR_ZERO, CMD_WORD_PGM);
                4'h1: seq_step = mk(SK_W, ADDR_ZERO, DAT_ZERO);
                4'h2: seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
                default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
              endcase
            OP_GUARD_UNLOCK: // password goes out low word first
              if (b == 4'h0)
                seq_step = mk(SK_W, ADDR_ZERO, CMD_UNLOCK);
              else if (b <= 4'(PWD_WORDS))
                seq_step = mk(SK_W, FA_W'(b - 4'h1), pw[(b - 4'h1) * FD_W +: FD_W]);
              else if (b == 4'(PWD_WORDS + 1))
                seq_step = mk(SK_W, ADDR_ZERO, CMD_CONFIRM);
              else if (b == 4'(PWD_WORDS + 2))
                seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
            OP_MODE_PROG: // lock word program, a timed algorithm
              case (b)
                4'h0: seq_step = mk(SK_W, ADDR_ZERO, CMD_WORD_PGM);
                4'h1: seq_step = mk(SK_W, ADDR_ZERO, r.data);
                4'h2: seq_step = mk(SK_POLL, ADDR_ZERO, DAT_ZERO);
                4'h3: seq_step = mk(SK_W, ADDR_ZERO, CMD_EXIT);
                default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
              endcase
            default: seq_step = mk(SK_END, ADDR_ZERO, DAT_ZERO);
          endcase
        end
      end
    endcase
  endfunction

  assign cur = seq_step(req_q, step, pwd_q);

  // pin data passes two flops before the engine looks at it
  always_ff @(posedge clk_sys)
  begin
    dq_meta <= dq_in;
    dq_sync <= dq_meta;
  end

  // next-state logic of the bus engine
  always_comb
  begin
    next_state      = state;
    next_req_q      = req_q;
    next_pwd_q      = pwd_q;
    next_step       = step;
    next_cnt        = cnt;
    next_poll_cnt   = poll_cnt;
    next_poll_first = poll_first;
    next_prev_tgl   = prev_tgl;
    next_pins       = pins;
    next_busy       = busy;
    next_resp_done  = 1'b0;
    next_resp_stat  = resp_stat;
    next_resp_rdata = resp_rdata;
    next_pins.wp_n  = ~wp_protect;
    case (state)
      S_IDLE:
        if (req_valid)
        begin
          next_req_q      = req;
          next_pwd_q      = pwd;
          next_step       = 4'h0;
          next_poll_first = 1'b1;
          next_poll_cnt   = 24'h000000;
          next_resp_stat  = RS_OK;
          if ((req.op == OP_GUARD_CLEAR && !nv_ready) ||
              (req.op == OP_MODE_PROG && !req.data[PMODE_BIT] && !req.data[WMODE_BIT]))
          begin
            // both mode bits at once would only abort, so refuse here
            next_resp_stat = RS_REFUSED;
            next_resp_done = 1'b1;
          end
          else if (req.op == OP_HW_RESET)
          begin
            next_pins.reset_n = 1'b0;
            next_cnt          = RP_CYC;
            next_busy         = 1'b1;
            next_state        = S_HWRST;
          end
          else
          begin
            next_busy  = 1'b1;
            next_state = S_FETCH;
          end
        end
      S_FETCH:
      begin
        next_pins.addr = cur.addr;
        case (cur.kind)
          SK_END:
          begin
            next_busy      = 1'b0;
            next_resp_done = 1'b1;
            next_state     = S_IDLE;
          end
          SK_W:
          begin
            next_pins.ce_n   = 1'b0;
            next_pins.dq_out = cur.data;
            next_pins.dq_oe  = 1'b1;
            next_state       = S_WSETUP;
          end
          default:
          begin
            // plain read or toggle poll
            next_pins.ce_n = 1'b0;
            next_pins.oe_n = 1'b0;
            next_cnt       = ACC_CYC;
            next_state     = S_RWAIT;
          end
        endcase
      end
      S_WSETUP:
      begin
        // one cycle of address setup before the strobe falls
        next_pins.we_n = 1'b0;
        next_cnt       = WP_CYC;
        next_state     = S_WSTRB;
      end
      S_WSTRB:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_pins.we_n = 1'b1;   // device takes the write on this rise
          next_state     = S_WHOLD;
        end
      end
      S_WHOLD:
      begin
        next_pins.ce_n  = 1'b1;
        next_pins.dq_oe = 1'b0;
        next_step       = step + 4'h1;
        next_state      = S_FETCH;
      end
      S_RWAIT:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_pins.ce_n  = 1'b1;
          next_pins.oe_n  = 1'b1;
          next_state      = S_FETCH;
          if (cur.kind == SK_R)
          begin
            next_resp_rdata = dq_sync;
            next_step       = step + 4'h1;
          end
          else if (poll_first)
          begin
            next_prev_tgl   = dq_sync[TGL_BIT];
            next_poll_first = 1'b0;
          end
          else if (dq_sync[TGL_BIT] == prev_tgl)
          begin
            // two equal reads: the algorithm has ended
            next_resp_rdata = dq_sync;
            next_poll_first = 1'b1;
            next_step       = step + 4'h1;
          end
          else if (poll_cnt == POLL_MAX)
          begin
            // stuck or refused algorithm: report and return it to standby
            next_resp_stat = RS_TIMEOUT;
            next_req_q.op  = OP_RESET_CMD;
            next_step      = 4'h0;
          end
          else
          begin
            next_prev_tgl = dq_sync[TGL_BIT];
            next_poll_cnt = poll_cnt + 24'h000001;
          end
        end
      end
      S_HWRST:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_pins.reset_n = 1'b1;
          next_cnt          = RH_CYC;
          next_state        = S_HWREC;
        end
      end
      S_HWREC:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_busy      = 1'b0;
          next_resp_done = 1'b1;
          next_state     = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // state registers; enables stay high through reset so the device powers up deselected
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state      <= S_IDLE;
      req_q      <= '{op: OP_READ, addr: ADDR_ZERO, data: DAT_ZERO};
      pwd_q      <= 64'h0000000000000000;
      step       <= 4'h0;
      cnt        <= 8'h00;
      poll_cnt   <= 24'h000000;
      poll_first <= 1'b1;
      prev_tgl   <= 1'b0;
      pins       <= PINS_IDLE;
      busy       <= 1'b0;
      resp_done  <= 1'b0;
      resp_stat  <= RS_OK;
      resp_rdata <= DAT_ZERO;
    end
    else
    begin
      state      <= next_state;
      req_q      <= next_req_q;
      pwd_q      <= next_pwd_q;
      step       <= next_step;
      cnt        <= next_cnt;
      poll_cnt   <= next_poll_cnt;
      poll_first <= next_poll_first;
      prev_tgl   <= next_prev_tgl;
      pins       <= next_pins;
      busy       <= next_busy;
      resp_done  <= next_resp_done;
      resp_stat  <= next_resp_stat;
      resp_rdata <= next_resp_rdata;
    end
  end

endmodule
`default_nettype wire

// file: testbench/fsp_host_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_host_checker
  import fsp_pkg::*;
#(
  parameter logic [23:0] POLL_MAX = 24'hffffff  // poll pair limit, unused here
)(
  // clock and reset
  input wire logic      clk_sys,
  input wire logic      rst_n,
  // user side
  input wire logic      req_valid,
  input wire fsp_req_s  req,
  input wire logic      nv_ready,
  input wire logic      wp_protect,
  input wire logic      busy,
  input wire logic      resp_done,
  input wire fsp_stat_e resp_stat,
  // flash pins
  input wire fsp_pins_s pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // engine is free to take a request at this edge
  wire logic take = req_valid && !busy && !resp_done;
  // reset parks the strobes so the device never wakes selected
  property p_rst_idle;
    disable iff (1'b0) !rst_n |=> pins.ce_n && pins.oe_n && pins.we_n && !pins.dq_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("strobes active in reset");
  // guard clear before sector bits are ready is turned away at once
  property p_refuse_clear;
    take && req.op == OP_GUARD_CLEAR && !nv_ready |=> resp_done && resp_stat == RS_REFUSED;
  endproperty
  a_refuse_clear: assert property (p_refuse_clear) else $error("early clear sent");
  // both mode bits at once would abort in the device, so refuse here
  property p_refuse_mode;
    take && req.op == OP_MODE_PROG && req.data[2:1] == 2'b00 |=> resp_stat == RS_REFUSED;
  endproperty
  a_refuse_mode: assert property (p_refuse_mode) else $error("double mode sent");
  // write strobe is one cycle low with the chip selected and data driven
  property p_we_pulse;
    $fell(pins.we_n) |-> !pins.ce_n && pins.dq_oe ##1 pins.we_n && !pins.ce_n && pins.dq_oe;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("bad write strobe");
  // a read holds output enable for the full access time, bus released
  property p_read_len;
    $fell(pins.oe_n) |-> (!pins.oe_n && !pins.ce_n && !pins.dq_oe) [*5] ##1 pins.oe_n;
  endproperty
  a_read_len: assert property (p_read_len) else $error("bad read cycle");
  // hardware reset pulse then recovery with the chip deselected
  property p_hw_pulse;
    $fell(pins.reset_n) |-> (!pins.reset_n && pins.ce_n) [*5] ##1 pins.reset_n && pins.ce_n;
  endproperty
  a_hw_pulse: assert property (p_hw_pulse) else $error("bad reset pulse");
  // write protect pin follows the user level one cycle later
  property p_wp_follow;
    $past(rst_n, 2) && $past(rst_n) |-> pins.wp_n == !$past(wp_protect);
  endproperty
  a_wp_follow: assert property (p_wp_follow) else $error("write protect stale");
  // done is a single pulse with the engine idle
  property p_done_idle;
    resp_done |-> !busy ##1 !resp_done;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done pulse wrong");
  c_timeout: cover property (resp_done && resp_stat == RS_TIMEOUT);
  c_refused: cover property (resp_done && resp_stat == RS_REFUSED);
  c_hw_reset: cover property ($rose(pins.reset_n));
endmodule
bind fsp_host fsp_host_checker #(.POLL_MAX(POLL_MAX)) i_chk (.clk_sys, .rst_n, .req_valid,
  .req, .nv_ready, .wp_protect, .busy, .resp_done, .resp_stat, .pins);
`default_nettype wire

// file: testbench/fsp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter logic [63:0] PASSWORD = 64'h1122334455667788  // arbitrary hidden password
)(
  // clock and pins
  input  wire logic       clk_sys,
  input  wire logic       por_n,       // low while powering up or supply below lockout
  input  wire fsp_pins_s  pins,
  input  wire logic [3:0] busy_reads,  // reads that toggle, prompt or slow
  // data toward the host
  output logic [FD_W-1:0] dq
);
  logic [2**SEC_W-1:0] nv = '1;     // sector bits delivered erased
  logic                guard = 1'b1; // persistent default sets it
  logic                wmode = 1'b0; // password mode chosen
  logic [1:0]          pre = 2'h0;   // prefix progress
  logic [1:0]          ovl = 2'h0;   // 1 sector bits, 2 guard, 3 lock word
  logic [FD_W-1:0]     last = '0;    // previous command word
  logic [FD_W-1:0]     held = '0;    // last word driven
  logic [2:0]          pw_n = 3'h0;  // password words still due
  logic [63:0]         pw_got = '0;
  logic [4:0]          tgl = 5'h0;   // toggling reads left, 1f never ends
  logic                tbit = 1'b0;
  logic                we_q = 1'b1;
  logic                oe_q = 1'b1;
  wire logic [FD_W-1:0]  d = pins.dq_out;
  wire logic [SEC_W-1:0] sec = pins.addr[FA_W-1:SEC_LSB]; // sector from A16 up
  wire logic [PAT_W-1:0] pat = pins.addr[PAT_W-1:0];      // pattern on A10..A0
  wire logic             rd_on = por_n && !pins.ce_n && !pins.oe_n; // silent at power-up
  // busy flag, else overlay bit in bit zero, else array word, never a command
  wire logic [FD_W-1:0] rd = (tgl != 5'h0) ? {9'h0, tbit, 6'h0} :
                             (ovl == 2'h1) ? {15'h0, nv[sec]} : pins.addr[15:0];
  // released bus shows the inverse, so a stale copy cannot pass
  assign dq = rd_on ? rd : ~held;
  // every host write is decoded when the write strobe rises
  always @(posedge clk_sys)
  begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    if (rd_on)
      held <= rd;
    // power-up and lockout take no writes and leave the controller in read mode
    if (!pins.reset_n || !por_n)
      {guard, pre, ovl, tgl, pw_n} <= {!wmode, 12'h0};
    else if (!oe_q && pins.oe_n && tgl != 5'h0)
    begin
      tbit <= !tbit;
      tgl  <= (tgl == 5'h1f) ? tgl : tgl - 5'h1;      // locked guard never ends
    end
    else if (pins.we_n && !we_q && !pins.ce_n)
    begin
      last <= d;
      if (pw_n != 3'h0)
      begin
        pw_got <= {d, pw_got[63:16]};  // low word first
        pw_n   <= pw_n - 3'h1;
        last   <= last;                // keep the unlock code across the words
      end
      else if (d == CMD_EXIT || d == CMD_RESET)
        {pre, ovl, tgl} <= 9'h0;
      else if (pre == 2'h0)
        pre <= (pat == UNL1_PAT && d == UNL1_DAT) ? 2'h1 : 2'h0;
      else if (pre == 2'h1)
        pre <= (pat == UNL2_PAT && d == UNL2_DAT) ? 2'h2 : 2'h0;
      else if (pre == 2'h2)
        {pre, ovl} <= {2'h3, (d == CMD_NV_ENTER) ? 2'h1 : (d == CMD_GUARD_ENTER) ? 2'h2 :
                       (d == CMD_LOCK_ENTER) ? 2'h3 : 2'h0};
      else if (last == CMD_WORD_PGM && ovl == 2'h1)
      begin
        nv[sec] <= nv[sec] & !guard;                    // one bit, guard honoured
        tgl     <= guard ? {1'b0, busy_reads} : 5'h1f;
      end
      else if (last == CMD_WORD_PGM && ovl == 2'h2)
        guard <= 1'b0;
      else if (last == CMD_WORD_PGM && ovl == 2'h3 && d[2:1] != 2'b00)
        {wmode, tgl} <= {wmode | !d[2], 1'b0, busy_reads};
      else if (last == CMD_ERASE && d == CMD_CONFIRM)
      begin
        nv  <= guard ? '1 : nv;                         // all together
        tgl <= guard ? {1'b0, busy_reads} : 5'h1f;
      end
      else if (d == CMD_UNLOCK)
        pw_n <= 3'h4;
      else if (last == CMD_UNLOCK && d == CMD_CONFIRM && pw_got == PASSWORD && wmode)
        guard <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/fsp_host_test.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_host_test
  import fsp_pkg::*;
();
  localparam logic [63:0] PWD = 64'h1122334455667788; // arbitrary password
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   req_valid = 1'b0;
  fsp_req_s               req = '0;
  logic [63:0]            pwd = '0;
  logic                   nv_ready = 1'b0;
  logic                   wp_protect = 1'b0;
  logic [3:0]             busy_reads = 4'h0; // partner busy length
  logic                   busy;
  logic                   resp_done;
  fsp_stat_e              resp_stat;
  logic [FD_W-1:0]        resp_rdata;
  logic [FD_W-1:0]        dq_in;
  logic [FD_W-1:0]        flash_dq;
  fsp_pins_s              pins;
  logic [SEC_W-1:0]       s_a;
  int                     err_count = 0;
  int                     tests_run = 0;
  // short poll limit keeps hung bit commands brief
  fsp_host #(.POLL_MAX(24'h8)) i_dut (.clk_sys, .rst_n, .req_valid, .req, .pwd, .nv_ready,
    .wp_protect, .busy, .resp_done, .resp_stat, .resp_rdata, .pins, .dq_in);
  // bench reset doubles as the device's power-up period
  fsp_flash_model #(.PASSWORD(PWD)) i_flash (.clk_sys, .por_n(rst_n), .pins, .busy_reads,
    .dq(flash_dq));
  // shared data wire: host wins while it drives
  assign dq_in = pins.dq_oe ? pins.dq_out : flash_dq;
  initial
    forever #20 clk_sys = ~clk_sys;
  // verdict and stop
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (!ok)
    begin
      err_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // partner returns the low address bits as array data
  function automatic logic [FD_W-1:0] array_word(input logic [FA_W-1:0] a);
    return a[15:0];
  endfunction
  // one request, bounded wait for done, status compare
  task automatic run(input fsp_op_e op, input logic [FA_W-1:0] a, input logic [FD_W-1:0] d,
                     input fsp_stat_e st);
    int n;
    @(posedge clk_sys);
    req_valid  <= 1'b1;
    req        <= '{op: op, addr: a, data: d};
    busy_reads <= 4'($urandom_range(6));
    wp_protect <= 1'($urandom);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (n = 0; n < 4000 && resp_done !== 1'b1; n++)
      @(posedge clk_sys);
    if (n == 4000)
    begin
      err_count++;
      $display("Error at %0t: no response", $time);
      end_sim();
    end
    check(resp_stat === st, "wrong status");
  endtask
  task automatic status(input logic [SEC_W-1:0] s, input logic b);
    run(OP_NV_STATUS, {s, 16'h0}, DAT_ZERO, RS_OK);
    check(resp_rdata === {15'h0, b}, "sector bit");
  endtask
  initial
  begin
    logic [FA_W-1:0] a;
    void'($urandom(32'h5801));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_a = SEC_W'($urandom);
    status(s_a, 1'b1);
    repeat (6)
    begin
      a = FA_W'($urandom);
      run(OP_READ, a, DAT_ZERO, RS_OK);
      check(resp_rdata === array_word(a), "array read");
      run(OP_WRITE, a, 16'($urandom_range(16'hffff, 16'h1000)), RS_OK);
    end
    run(OP_NV_PROG, {s_a, 16'h0}, DAT_ZERO, RS_OK);
    status(s_a, 1'b0);
    status(s_a ^ 10'h1, 1'b1);
    run(OP_GUARD_CLEAR, ADDR_ZERO, DAT_ZERO, RS_REFUSED);
    nv_ready <= 1'b1;
    run(OP_GUARD_CLEAR, ADDR_ZERO, DAT_ZERO, RS_OK);
    run(OP_NV_ERASE, ADDR_ZERO, DAT_ZERO, RS_TIMEOUT);
    status(s_a, 1'b0);
    run(OP_HW_RESET, ADDR_ZERO, DAT_ZERO, RS_OK);
    run(OP_NV_ERASE, ADDR_ZERO, DAT_ZERO, RS_OK);
    status(s_a, 1'b1);
    run(OP_RESET_CMD, ADDR_ZERO, DAT_ZERO, RS_OK);
    run(OP_MODE_PROG, ADDR_ZERO, 16'hfff9, RS_REFUSED);
    run(OP_MODE_PROG, ADDR_ZERO, 16'hfffb, RS_OK);
    run(OP_HW_RESET, ADDR_ZERO, DAT_ZERO, RS_OK);
    pwd <= ~PWD;
    run(OP_GUARD_UNLOCK, ADDR_ZERO, DAT_ZERO, RS_OK);
    run(OP_NV_PROG, {s_a, 16'h0}, DAT_ZERO, RS_TIMEOUT);
    pwd <= PWD;
    run(OP_GUARD_UNLOCK, ADDR_ZERO, DAT_ZERO, RS_OK);
    run(OP_NV_PROG, {s_a, 16'h0}, DAT_ZERO, RS_OK);
    status(s_a, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
